// ==== mqrs_defines.vh ====
`ifndef MQRS_DEFINES_VH
`define MQRS_DEFINES_VH

// ----------------------------------------------------------------------
// Register map: start words of the eight segments
// ----------------------------------------------------------------------
`define MQRS_OPER_MSG_READ_SEG       16'h0006
`define MQRS_RESPONSE_VAL_READ_SEG   16'h001F
`define MQRS_XFMR_TYPE_READ_SEG      16'h0038
`define MQRS_CORR_FACTOR_READ_SEG    16'h0051
`define MQRS_XFMR_MONITOR_READ_SEG   16'h006A
`define MQRS_CHAN_FUNCTION_READ_SEG  16'h0083
`define MQRS_DELAY_READ_SEG          16'h009C
`define MQRS_MEASURED_VAL_READ_SEG   16'h00B5
`define MQRS_OPER_MSG_CONFIG         16'h0406
`define MQRS_RESPONSE_VAL_CONFIG     16'h041F
`define MQRS_XFMR_TYPE_CONFIG        16'h0438
`define MQRS_CORR_FACTOR_CONFIG      16'h0451
`define MQRS_XFMR_MONITOR_CONFIG     16'h046A
`define MQRS_CHAN_FUNCTION_CONFIG    16'h0483
`define MQRS_DELAY_CONFIG            16'h049C
`define MQRS_MEASURED_VAL_CONFIG     16'h04B5

// ----------------------------------------------------------------------
// Query codes accepted in mode 1, one per segment
// ----------------------------------------------------------------------
`define MQRS_CODE_OPER_MSG      8'h04
`define MQRS_CODE_RESPONSE_VAL  8'h1E
`define MQRS_CODE_XFMR_TYPE     8'h20
`define MQRS_CODE_CORR_FACTOR   8'h23
`define MQRS_CODE_XFMR_MONITOR  8'h25
`define MQRS_CODE_CHAN_FUNCTION 8'h27
`define MQRS_CODE_DELAY         8'h30
`define MQRS_CODE_MEASURED_VAL  8'h69

// ----------------------------------------------------------------------
// Segment layout and data types
// ----------------------------------------------------------------------
`define MQRS_SEG_COUNT      8
`define MQRS_SEG_WORDS      25
`define MQRS_CHANNELS       12
`define MQRS_TYPE_NO_MSG    16'h0001
`define MQRS_TYPE_NO_XFMR   16'h0016
`define MQRS_TYPE_MILLIAMP  16'h0037
`define MQRS_STAT_NORMAL    2'h0
`define MQRS_STAT_NO_XFMR   2'h1
`define MQRS_STAT_NO_MSG    2'h2

// ----------------------------------------------------------------------
// Timing: reply timeout 1 ms at 4 ns per cycle
// ----------------------------------------------------------------------
`define MQRS_REPLY_TIMEOUT_NS  1000000
`define MQRS_CLK_PERIOD_NS     4
`define MQRS_REPLY_TIMEOUT_CYC (`MQRS_REPLY_TIMEOUT_NS / `MQRS_CLK_PERIOD_NS)

`endif

// ==== mqrs_register_segments.v ====
// Function
// - Only the eight mode-1 query codes 4,30,32,35,37,39,48,105 are accepted.
// - Configuration words live at 0406h..04B5h, one per code in order.
// - After one configuration write the segment at 0006h..00B5h stays served.
// - First read word echoes configured code high byte, address low byte.
// - Then twelve channels, value word then type word, positions 2 to 25.
// - Operating-message query: absent transformer reports value 0, type 22.
// - Channel without operating message reports value 0, type 1.
// - Type 55 marks the value word as residual current in milliamperes.
`timescale 1ns/1ps
`include "mqrs_defines.vh"

module mqrs_register_segments #(
  parameter SEGS        = `MQRS_SEG_COUNT,
  parameter CHANS       = `MQRS_CHANNELS,
  parameter TIMEOUT_CYC = `MQRS_REPLY_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Register port toward the Modbus side
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [15:0] regAddr,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  output reg         regAck,
  output reg         regError,
  // Query toward the measuring bus
  output reg         qryValid,
  output reg  [7:0]  qryCode,
  output reg  [7:0]  qryAddr,
  input  wire        qryReady,
  // Reply from the measuring bus, one channel per pulse
  input  wire        rspValid,
  input  wire [3:0]  rspChan,
  input  wire [1:0]  rspStatus,
  input  wire        rspMilliamp,
  input  wire [15:0] rspValue,
  input  wire [15:0] rspType,
  input  wire        rspDone,
  // Status
  output reg         busy,
  output reg  [7:0]  segServed
);

  // ----------------------------------------------------------------------
  // Local constants and state codes
  // ----------------------------------------------------------------------
  localparam MEM_WORDS = SEGS * (`MQRS_SEG_WORDS - 1);
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_ISSUE = 3'h2;
  localparam [2:0] ST_WAIT  = 3'h4;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Query code that belongs to a segment
  function [7:0] segCode;
    input [2:0] s;
    begin
      case (s)
        3'h0: segCode = `MQRS_CODE_OPER_MSG;
        3'h1: segCode = `MQRS_CODE_RESPONSE_VAL;
        3'h2: segCode = `MQRS_CODE_XFMR_TYPE;
        3'h3: segCode = `MQRS_CODE_CORR_FACTOR;
        3'h4: segCode = `MQRS_CODE_XFMR_MONITOR;
        3'h5: segCode = `MQRS_CODE_CHAN_FUNCTION;
        3'h6: segCode = `MQRS_CODE_DELAY;
        default: segCode = `MQRS_CODE_MEASURED_VAL;
      endcase
    end
  endfunction

  // Decode address against a segment base: {hit, segment, word offset}
  function [13:0] segDecode;
    input [15:0] addr;
    input [15:0] base;
    integer      i;
    reg   [15:0] start;
    reg   [15:0] diff;
    begin
      segDecode = 14'h0000;
      for (i = 0; i < SEGS; i = i + 1) begin
        start = base + i[15:0] * 16'h0019;
        diff  = addr - start;
        // Offset never exceeds 24 inside a hit, so five bits suffice
        if (addr >= start && addr < start + 16'h0019) begin
          segDecode = {1'b1, i[2:0], 5'h00, diff[4:0]};
        end
      end
    end
  endfunction

  // Memory index of a data word: segment, channel, value/type select
  function [7:0] memIndex;
    input [2:0] s;
    input [3:0] ch;
    input       isType;
    begin
      memIndex = s * 8'h18 + ch * 8'h02 + {7'h00, isType};
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg  [15:0] segMem [0:MEM_WORDS-1];
  reg  [15:0] cfgReg [0:SEGS-1];
  reg  [7:0]  dataValid_reg;
  reg  [7:0]  pending_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  curSeg_reg;
  reg  [31:0] timer_reg;
  reg  [15:0] wrValue;
  reg  [15:0] wrType;
  reg  [2:0]  pickSeg;
  reg         pickAny;
  integer     k;
  integer     j;

  wire [13:0] cfgHit  = segDecode(regAddr, `MQRS_OPER_MSG_CONFIG);
  wire [13:0] readHit = segDecode(regAddr, `MQRS_OPER_MSG_READ_SEG);
  // Data word offset: channel in the upper bits, type select in bit 0
  wire [4:0]  rdOff   = readHit[4:0] - 5'h01;
  wire        cfgAddrOk = cfgHit[13] && (cfgHit[4:0] == 5'h00);
  wire        codeOk    = (regWdata[15:8] == segCode(cfgHit[12:10]));
  wire        cfgAccept = regWrite && cfgAddrOk && codeOk;

  // ----------------------------------------------------------------------
  // Reply word shaping
  // ----------------------------------------------------------------------
  // Status coding wins over raw reply fields so the master sees fixed words
  always @* begin
    wrValue = rspValue;
    wrType  = rspType;
    if (rspStatus == `MQRS_STAT_NO_XFMR && curSeg_reg == 3'h0) begin
      wrValue = 16'h0000;
      wrType  = `MQRS_TYPE_NO_XFMR;
    end else if (rspStatus == `MQRS_STAT_NO_MSG) begin
      wrValue = 16'h0000;
      wrType  = `MQRS_TYPE_NO_MSG;
    end else if (rspMilliamp) begin
      wrType  = `MQRS_TYPE_MILLIAMP;
    end
  end

  // Lowest pending segment gets the next query
  always @* begin
    pickSeg = 3'h0;
    pickAny = 1'b0;
    for (k = SEGS - 1; k >= 0; k = k - 1) begin
      if (pending_reg[k]) begin
        pickSeg = k[2:0];
        pickAny = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  // Reads answer one cycle later; unserved or unmapped words flag an error
  always @(posedge clk) begin
    if (!resetn) begin
      regRdata      <= 16'h0000;
      regAck        <= 1'b0;
      regError      <= 1'b0;
      segServed     <= 8'h00;
      dataValid_reg <= 8'h00;
      for (j = 0; j < SEGS; j = j + 1)
        cfgReg[j] <= 16'h0000;
    end else begin
      regAck   <= regRead || regWrite;
      regError <= 1'b0;
      regRdata <= 16'h0000;
      if (regWrite) begin
        if (cfgAccept) begin
          cfgReg[cfgHit[12:10]]        <= regWdata;
          segServed[cfgHit[12:10]]     <= 1'b1;
          dataValid_reg[cfgHit[12:10]] <= 1'b0;
        end else begin
          regError <= 1'b1;
        end
      end else if (regRead) begin
        if (cfgAddrOk) begin
          regRdata <= cfgReg[cfgHit[12:10]];
        end else if (readHit[13] && segServed[readHit[12:10]]) begin
          if (readHit[4:0] == 5'h00)
            regRdata <= cfgReg[readHit[12:10]];
          else if (dataValid_reg[readHit[12:10]])
            regRdata <= segMem[memIndex(readHit[12:10], rdOff[4:1], rdOff[0])];
        end else begin
          regError <= 1'b1;
        end
      end
      if (state_reg == ST_WAIT && rspDone)
        dataValid_reg[curSeg_reg] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Reply capture into the segment memory
  // ----------------------------------------------------------------------
  // Memory holds no reset; dataValid gates reads of stale words instead
  always @(posedge clk) begin
    if (state_reg == ST_WAIT && rspValid && rspChan < CHANS) begin
      segMem[memIndex(curSeg_reg, rspChan, 1'b0)] <= wrValue;
      segMem[memIndex(curSeg_reg, rspChan, 1'b1)] <= wrType;
    end
  end

  // ----------------------------------------------------------------------
  // Query sequencer
  // ----------------------------------------------------------------------
  // A new write sets its pending bit even while it is being cleared
  always @(posedge clk) begin
    if (!resetn) begin
      state_reg   <= ST_IDLE;
      pending_reg <= 8'h00;
      curSeg_reg  <= 3'h0;
      timer_reg   <= 32'h00000000;
      qryValid    <= 1'b0;
      qryCode     <= 8'h00;
      qryAddr     <= 8'h00;
      busy        <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (pickAny) begin
            pending_reg[pickSeg] <= 1'b0;
            curSeg_reg <= pickSeg;
            qryCode    <= cfgReg[pickSeg][15:8];
            qryAddr    <= cfgReg[pickSeg][7:0];
            qryValid   <= 1'b1;
            busy       <= 1'b1;
            state_reg  <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (qryReady) begin
            qryValid  <= 1'b0;
            timer_reg <= 32'h00000000;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Timeout keeps a dead device from blocking the other segments
          timer_reg <= timer_reg + 32'h00000001;
          if (rspDone || timer_reg >= TIMEOUT_CYC - 1) begin
            busy      <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (cfgAccept)
        pending_reg[cfgHit[12:10]] <= 1'b1;
    end
  end

endmodule

// ==== mqrs_properties.sv ====
`timescale 1ns/1ps
module mqrs_properties #(
  parameter TIMEOUT_CYC = 20
) (
  // Clock, reset, register port
  input wire        clk,
  input wire        resetn,
  input wire        regWrite,
  input wire        regRead,
  input wire [15:0] regAddr,
  input wire [15:0] regWdata,
  input wire [15:0] regRdata,
  input wire        regAck,
  input wire        regError,
  // Query side and status
  input wire        qryValid,
  input wire [7:0]  qryCode,
  input wire        qryReady,
  input wire        busy,
  input wire [7:0]  segServed
);
  // ----------------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------------
  // Slack over the timeout covers a slow taker before the count starts
  localparam int BUSY_MAX = TIMEOUT_CYC + 20;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ack_follows: assert property ((regWrite || regRead) |=> regAck)
    else $error("no ack after strobe");
  a_ack_alone: assert property (!(regWrite || regRead) |=> !regAck)
    else $error("ack without strobe");
  a_rdata_idle: assert property (!regAck |-> regRdata == 16'h0000)
    else $error("read data outside ack");
  a_bad_code: assert property (regWrite && regAddr == 16'h0406 && regWdata[15:8] != 8'h04 |=> regError)
    else $error("wrong code accepted");
  a_good_query: assert property (regWrite && regAddr == 16'h0406 && regWdata[15:8] == 8'h04 && !busy
    |=> !regError && segServed[0] ##1 qryValid && qryCode == 8'h04)
    else $error("config write gave no query");
  a_served_keep: assert property (&(segServed | ~$past(segServed)))
    else $error("served segment dropped");
  a_unserved_read: assert property (regRead && regAddr == 16'h0006 && !segServed[0]
    |=> regError && regRdata == 16'h0000)
    else $error("unserved segment read");
  a_qry_hold: assert property (qryValid && !qryReady |=> qryValid && $stable(qryCode))
    else $error("query withdrawn");
  a_qry_drop: assert property (qryValid && qryReady |=> !qryValid)
    else $error("query kept after take");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
    else $error("busy never ends");
  c_refused: cover property (regAck && regError);
  c_stall: cover property (qryValid && !qryReady);
  c_done: cover property ($fell(busy));
endmodule
bind mqrs_register_segments mqrs_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) chkI (.clk(clk), .resetn(resetn),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .regAck(regAck), .regError(regError), .qryValid(qryValid), .qryCode(qryCode), .qryReady(qryReady),
  .busy(busy), .segServed(segServed));

// ==== mqrs_partner.sv ====
`timescale 1ns/1ps
module mqrs_partner (
  // Clock and reset
  input  wire         clk,
  input  wire         resetn,
  // Query in, reply out
  input  wire         qryValid,
  input  wire  [7:0]  qryCode,
  input  wire  [7:0]  qryAddr,
  output logic        qryReady    = 1'b0,
  output logic        rspValid    = 1'b0,
  output logic [3:0]  rspChan     = 4'hF,
  output logic [1:0]  rspStatus   = 2'h3,
  output logic        rspMilliamp = 1'b0,
  output logic [15:0] rspValue    = 16'hA5A5,
  output logic [15:0] rspType     = 16'h5A5A,
  output logic        rspDone     = 1'b0,
  // Behaviour select
  input  wire         slow,
  input  wire         mute
);
  // ----------------------------------------------------------------------
  // Measuring-bus device
  // ----------------------------------------------------------------------
  integer     n = 0;
  integer     d = 0;
  logic [7:0] qc = 8'h00;
  logic [7:0] qa = 8'h00;
  wire  [3:0] ch = 4'(n - 1);
  // Idle reply lines toggle so stale values never look valid
  always @(posedge clk) begin
    qryReady <= 1'b0;
    rspValid <= 1'b0;
    rspDone <= 1'b0;
    {rspChan, rspStatus, rspMilliamp, rspValue, rspType} <= ~{rspChan, rspStatus, rspMilliamp, rspValue, rspType};
    if (!resetn) begin
      n <= 0;
      d <= 0;
    end else if (n == 0) begin
      d <= qryValid ? d + 1 : 0;
      if (qryValid && qryReady) begin
        n <= mute ? 0 : 1;
        qc <= qryCode;
        qa <= qryAddr;
      end else if (qryValid && d >= (slow ? 3 : 0)) qryReady <= 1'b1;
    end else if (n <= 12) begin
      rspValid <= 1'b1;
      rspChan <= ch;
      rspStatus <= 2'(ch % 3);
      rspMilliamp <= ch[0];
      rspValue <= {qa, qc ^ {4'h0, ch}};
      rspType <= {12'h000, ch};
      n <= n + 1;
    end else begin
      rspDone <= 1'b1;
      n <= 0;
    end
  end
endmodule

// ==== mqrs_register_segments_tb_top.sv ====
`timescale 1ns/1ps
module mqrs_register_segments_tb_top;
  // ----------------------------------------------------------------------
  // Wiring and model state
  // ----------------------------------------------------------------------
  logic        clk = 0, resetn = 0, regWrite = 0, regRead = 0, slow = 0, mute = 0;
  logic [15:0] regAddr = 0, regWdata = 0, lfsrReg = 16'h0005, rd, cfg[8];
  wire  [15:0] regRdata, rspValue, rspType;
  wire         regAck, regError, qryValid, qryReady, rspValid, rspMilliamp, rspDone, busy;
  wire  [7:0]  qryCode, qryAddr, segServed;
  wire  [3:0]  rspChan;
  wire  [1:0]  rspStatus;
  logic [7:0]  codes[8] = '{8'h04, 8'h1E, 8'h20, 8'h23, 8'h25, 8'h27, 8'h30, 8'h69};
  logic [15:0] cfgA[8] = '{16'h0406, 16'h041F, 16'h0438, 16'h0451, 16'h046A, 16'h0483, 16'h049C, 16'h04B5};
  logic [15:0] segA[8] = '{16'h0006, 16'h001F, 16'h0038, 16'h0051, 16'h006A, 16'h0083, 16'h009C, 16'h00B5};
  int          fail_count = 0, n_checks = 0, cyc = 0, s, done[8];
  mqrs_register_segments #(.TIMEOUT_CYC(20)) dut (.clk(clk), .resetn(resetn), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
    .regError(regError), .qryValid(qryValid), .qryCode(qryCode), .qryAddr(qryAddr), .qryReady(qryReady),
    .rspValid(rspValid), .rspChan(rspChan), .rspStatus(rspStatus), .rspMilliamp(rspMilliamp),
    .rspValue(rspValue), .rspType(rspType), .rspDone(rspDone), .busy(busy), .segServed(segServed));
  mqrs_partner ptn (.clk(clk), .resetn(resetn), .qryValid(qryValid), .qryCode(qryCode), .qryAddr(qryAddr),
    .qryReady(qryReady), .rspValid(rspValid), .rspChan(rspChan), .rspStatus(rspStatus),
    .rspMilliamp(rspMilliamp), .rspValue(rspValue), .rspType(rspType), .rspDone(rspDone),
    .slow(slow), .mute(mute));
  // Clock and hang guard
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fail_count++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkb(string nm, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  function logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Word w of segment s as the reply shaping predicts it
  function logic [15:0] expw(int s, int w);
    int c, st;
    c = (w - 1) / 2;
    st = c % 3;
    if (w == 0) return cfg[s];
    if (done[s] == 0) return 16'h0000;
    if (st == 2 || (st == 1 && s == 0)) return w[0] ? 16'h0000 : (st == 2 ? 16'h0001 : 16'h0016);
    return w[0] ? {cfg[s][7:0], codes[s] ^ 8'(c)} : (c[0] ? 16'h0037 : 16'(c));
  endfunction
  // One register cycle; answer taken with the ack
  task bus(logic w, logic [15:0] a, d, logic e);
    @(posedge clk);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    #1 rd = regRdata;
    chkb("ack", 1'b1, regAck);
    chkb("error", e, regError);
  endtask
  task idle();
    int i;
    repeat (3) @(posedge clk);
    #1;
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk) #1;
  endtask
  task cfgw(int s, logic sl, logic mu);
    slow <= sl;
    mute <= mu;
    lfsrReg = lfsr(lfsrReg);
    cfg[s] = {codes[s], lfsrReg[7:0]};
    done[s] = 0;
    bus(1'b1, cfgA[s], cfg[s], 1'b0);
    idle();
    chkb("idle", 1'b0, busy);
    done[s] = !mu;
  endtask
  task rdseg(int s);
    for (int w = 0; w < 25; w++) begin
      bus(1'b0, segA[s] + 16'(w), 16'h0000, 1'b0);
      chk("word", expw(s, w), rd);
    end
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, 16'h0006, 16'h0000, 1'b1);
    chk("unserved", 16'h0000, rd);
    bus(1'b0, 16'h0300, 16'h0000, 1'b1);
    bus(1'b1, 16'h0007, 16'h0405, 1'b1);
    for (s = 0; s < 8; s++) bus(1'b1, cfgA[s], {codes[s] + 8'h01, 8'h05}, 1'b1);
    $display("test refusals done");
    for (s = 0; s < 8; s++) begin
      cfgw(s, s[0], 1'b0);
      rdseg(s);
    end
    $display("test segments done");
    cfgw(1, 1'b0, 1'b1);
    rdseg(1);
    rdseg(0);
    $display("test timeout done");
    finish_test();
  end
endmodule
